/* ncsu_pkg.sv */
// What this block does
// RULE_01 - Free-space threshold 0..2044, above 1792 disables
// RULE_02 - Free-space cause when free bytes exceed threshold
// RULE_03 - Acknowledging free-space restores the disabled threshold
// RULE_04 - Start sending on threshold or whole packet
// RULE_05 - Start threshold dword-truncated, default 1792, above whole-packet
// RULE_06 - Statistics off at power-up, enable command starts
// RULE_07 - Updates held while disabled, applied after enable; the code holds at most 15 and drops the rest
// RULE_08 - Host disables statistics before reading counters
// RULE_09 - Stop command switches off coaxial converter
// RULE_10 - Host waits 800 us before using AUI
// RULE_11 - Reclaim threshold 3 bits, 256-byte steps, 111 off
// RULE_12 - Reclaim frees per byte; late collision aborts
// RULE_13 - Full power at reset and on power-up command
// RULE_14 - Host resets transmit and receive after wake
// RULE_15 - Power-down stops converter, only power-up accepted
// RULE_16 - State kept in power-down; converter stays off
// RULE_17 - Auto power idles low, wakes on activity
// RULE_18 - Host follows auto power with power-up
// RULE_19 - Status read-only, 16 bits, byte reads allowed
// RULE_20 - Window, busy, reserved zeros, eight cause bits
// RULE_21 - Causes 7..1 interrupt unless either mask clears
// RULE_22 - Host reset clears cause bits, not conditions
// RULE_23 - Upper five bits opcode, lower eleven argument
package ncsu_pkg;
  localparam int CNT_W = 11;
  localparam logic [3:0] STATUS_PORT = 4'hE;
  localparam logic [3:0] CMD_PORT = 4'hE;
  localparam logic [15:0] READ_NONE = 16'h0000;
  // Command field layout
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int ARG_W = 11;
  // Opcodes
  localparam logic [4:0] OP_SEL_WINDOW = 5'h01;
  localparam logic [4:0] OP_COAX_ON = 5'h02;
  localparam logic [4:0] OP_REQ_INT = 5'h0C;
  localparam logic [4:0] OP_ACK_INT = 5'h0D;
  localparam logic [4:0] OP_INT_MASK = 5'h0E;
  localparam logic [4:0] OP_RZ_MASK = 5'h0F;
  localparam logic [4:0] OP_TX_AVAIL = 5'h12;
  localparam logic [4:0] OP_TX_START = 5'h13;
  localparam logic [4:0] OP_STATS_ON = 5'h15;
  localparam logic [4:0] OP_STATS_OFF = 5'h16;
  localparam logic [4:0] OP_COAX_OFF = 5'h17;
  localparam logic [4:0] OP_RECLAIM = 5'h18;
  localparam logic [4:0] OP_POWER_UP = 5'h1B;
  localparam logic [4:0] OP_POWER_DOWN = 5'h1C;
  localparam logic [4:0] OP_POWER_AUTO = 5'h1D;
  // Thresholds
  localparam logic [CNT_W-1:0] THR_MAX = 11'h700;
  localparam logic [CNT_W-1:0] AVAIL_DISABLED = 11'h7FC;
  localparam logic [CNT_W-1:0] START_RESET = 11'h700;
  localparam logic [2:0] RECLAIM_OFF = 3'h7;
  localparam int RECLAIM_SHIFT = 8;
  // Status layout
  localparam int WIN_HI = 15;
  localparam int WIN_LO = 13;
  localparam int BUSY_BIT = 12;
  localparam int C_LATCH = 0;
  localparam int C_FAIL = 1;
  localparam int C_TXDONE = 2;
  localparam int C_FREE = 3;
  localparam int C_RXDONE = 4;
  localparam int C_RXEARLY = 5;
  localparam int C_REQ = 6;
  localparam int C_UPDATE = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] WIN_RESET = 3'h0;
  // Wake-up busy time after a power-up command
  localparam int WAKE_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int WAKE_CYCLES = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {NCSU_FULL, NCSU_DOWN, NCSU_AUTO_LOW, NCSU_AUTO_UP} ncsu_pwr_t;
endpackage

/* ncsu_busy_timer.sv */
`timescale 1ns/1ps
module ncsu_busy_timer #(
  parameter int CYCLES = 40
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start) begin
      count <= LOAD;
      busy <= 1'b1;
    end else if (count != '0) begin
      count <= count - ONE;
      busy <= (count != ONE);
    end
  end
endmodule // ncsu_busy_timer

/* ncsu_top.sv */
`timescale 1ns/1ps
module ncsu_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host I/O port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_addr,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic host_reset,
  // Transmit FIFO side
  input wire logic [ncsu_pkg::CNT_W-1:0] tx_free_bytes,
  input wire logic [ncsu_pkg::CNT_W-1:0] tx_fifo_bytes,
  input wire logic tx_pkt_pending,
  input wire logic tx_pkt_whole,
  input wire logic [ncsu_pkg::CNT_W-1:0] tx_sent_bytes,
  input wire logic tx_byte_sent,
  input wire logic tx_collision,
  input wire logic tx_status_pending,
  input wire logic tx_status_pop,
  output logic tx_start_ok,
  output logic tx_reclaim_byte,
  output logic tx_abort,
  // Receive and failure conditions
  input wire logic rx_done,
  input wire logic rx_early,
  input wire logic rx_activity,
  input wire logic adapter_fail,
  // Statistics
  input wire logic stat_event,
  input wire logic stat_near_full,
  output logic stat_apply,
  output logic stats_enabled,
  // Power and interrupt
  output logic coax_on,
  output logic power_low,
  output logic int_out
);
  import ncsu_pkg::*;

  function automatic logic [CNT_W-1:0] dword_trunc(input logic [ARG_W-1:0] arg);
    return {arg[ARG_W-1:2], 2'b00};
  endfunction

  function automatic logic thr_on(input logic [CNT_W-1:0] thr);
    return thr <= THR_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic cmd_take;
  logic cmd_ok;
  logic [4:0] op;
  logic [ARG_W-1:0] arg;
  ncsu_pwr_t pstate;
  logic [2:0] window;
  logic [7:0] int_mask;
  logic [7:0] rz_mask;
  logic [CNT_W-1:0] avail_thr;
  logic [CNT_W-1:0] start_thr;
  logic [2:0] reclaim_thr;
  logic [7:0] cause;
  logic free_cause;
  logic req_cause;
  logic abort_cause;
  logic free_gt;
  logic free_gt_q;
  logic free_rise;
  logic ack_free;
  logic int_cond;
  logic reclaim_crossed;
  logic cmd_busy;
  logic [3:0] stat_pend;
  logic [CNT_W-1:0] reclaim_bytes;

  assign cmd_take = io_wr && io_addr == CMD_PORT && io_be == 2'b11;
  // RULE_23 opcode and argument split
  assign op = io_wdata[OP_HI:OP_LO];
  assign arg = io_wdata[ARG_W-1:0];
  // RULE_15 power-down filter
  assign cmd_ok = cmd_take && (pstate != NCSU_DOWN || op == OP_POWER_UP);

  function automatic logic is_cmd(input logic ok, input logic [4:0] code,
                                  input logic [4:0] want);
    return ok && code == want;
  endfunction

  ncsu_busy_timer #(
    .CYCLES(WAKE_CYCLES)
  ) u_busy (
    .clock(clock),
    .rst(rst),
    .start(is_cmd(cmd_ok, op, OP_POWER_UP) && pstate != NCSU_FULL),
    .busy(cmd_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // RULE_20 window number, host reset clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      window <= WIN_RESET;
    end else if (host_reset) begin
      window <= WIN_RESET;
    end else if (is_cmd(cmd_ok, op, OP_SEL_WINDOW)) begin
      window <= arg[2:0];
    end
  end

  // RULE_21 mask registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_mask <= MASK_RESET;
      rz_mask <= MASK_RESET;
    end else begin
      if (is_cmd(cmd_ok, op, OP_INT_MASK)) begin
        int_mask <= arg[7:0];
      end
      if (is_cmd(cmd_ok, op, OP_RZ_MASK)) begin
        rz_mask <= arg[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ack_free = is_cmd(cmd_ok, op, OP_ACK_INT) && arg[C_FREE];

  // RULE_01 free-space threshold, RULE_03 disabled again on acknowledge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avail_thr <= AVAIL_DISABLED;
    end else if (ack_free) begin
      avail_thr <= AVAIL_DISABLED;
    end else if (is_cmd(cmd_ok, op, OP_TX_AVAIL)) begin
      avail_thr <= dword_trunc(arg);
    end
  end

  // RULE_02 free bytes above threshold
  assign free_gt = thr_on(avail_thr) && tx_free_bytes > avail_thr;
  assign free_rise = free_gt && !free_gt_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      free_gt_q <= 1'b0;
    end else begin
      free_gt_q <= free_gt;
    end
  end

  // Edge set wins over acknowledge and host reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      free_cause <= 1'b0;
    end else if (free_rise) begin
      free_cause <= 1'b1;
    end else if (ack_free || host_reset) begin
      free_cause <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_cause <= 1'b0;
    end else if (is_cmd(cmd_ok, op, OP_REQ_INT)) begin
      req_cause <= 1'b1;
    end else if (host_reset || (is_cmd(cmd_ok, op, OP_ACK_INT) && arg[C_REQ])) begin
      req_cause <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_05 start threshold, dword truncated
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_thr <= START_RESET;
    end else if (is_cmd(cmd_ok, op, OP_TX_START)) begin
      start_thr <= dword_trunc(arg);
    end
  end

  // RULE_04 start on threshold or whole packet
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_start_ok <= 1'b0;
    end else begin
      tx_start_ok <= tx_pkt_pending && (tx_pkt_whole ||
                     (thr_on(start_thr) && tx_fifo_bytes > start_thr));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_11 reclaim threshold, 111 disables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reclaim_thr <= RECLAIM_OFF;
    end else if (is_cmd(cmd_ok, op, OP_RECLAIM)) begin
      reclaim_thr <= arg[2:0];
    end
  end

  assign reclaim_bytes = CNT_W'(reclaim_thr) << RECLAIM_SHIFT;
  assign reclaim_crossed = reclaim_thr != RECLAIM_OFF && tx_sent_bytes >= reclaim_bytes;

  // RULE_12 per-byte reclaim and collision abort
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_reclaim_byte <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_reclaim_byte <= reclaim_crossed && tx_byte_sent;
      tx_abort <= reclaim_crossed && tx_collision;
    end
  end

  // Held until the status entry is popped or a host reset; abort sets the transmit-done cause bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      abort_cause <= 1'b0;
    end else if (reclaim_crossed && tx_collision) begin
      abort_cause <= 1'b1;
    end else if (tx_status_pop || host_reset) begin
      abort_cause <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_06 statistics off at reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stats_enabled <= 1'b0;
    end else if (is_cmd(cmd_ok, op, OP_STATS_ON)) begin
      stats_enabled <= 1'b1;
    end else if (is_cmd(cmd_ok, op, OP_STATS_OFF)) begin
      stats_enabled <= 1'b0;
    end
  end

  // RULE_07 held updates drain one per cycle
  // Saturates at 15 held updates; a longer disable can lose some
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_pend <= 4'h0;
      stat_apply <= 1'b0;
    end else if (stats_enabled) begin
      stat_apply <= stat_event || stat_pend != 4'h0;
      if (!stat_event && stat_pend != 4'h0) begin
        stat_pend <= stat_pend - 4'h1;
      end
    end else begin
      stat_apply <= 1'b0;
      if (stat_event && stat_pend != 4'hF) begin
        stat_pend <= stat_pend + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_09 converter off, RULE_16 stays off until re-enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coax_on <= 1'b0;
    end else if (is_cmd(cmd_ok, op, OP_COAX_OFF) || is_cmd(cmd_ok, op, OP_POWER_DOWN)) begin
      coax_on <= 1'b0;
    end else if (is_cmd(cmd_ok, op, OP_COAX_ON)) begin
      coax_on <= 1'b1;
    end
  end

  // RULE_13 full power, RULE_15 down, RULE_17 auto
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pstate <= NCSU_FULL;
    end else if (is_cmd(cmd_ok, op, OP_POWER_UP)) begin
      pstate <= NCSU_FULL;
    end else if (is_cmd(cmd_ok, op, OP_POWER_DOWN)) begin
      pstate <= NCSU_DOWN;
    end else if (is_cmd(cmd_ok, op, OP_POWER_AUTO)) begin
      pstate <= rx_activity ? NCSU_AUTO_UP : NCSU_AUTO_LOW;
    end else begin
      case (pstate)
        NCSU_AUTO_LOW: pstate <= (rx_activity || tx_pkt_pending) ? NCSU_AUTO_UP : NCSU_AUTO_LOW;
        NCSU_AUTO_UP: pstate <= (rx_activity || tx_pkt_pending) ? NCSU_AUTO_UP : NCSU_AUTO_LOW;
        NCSU_DOWN: pstate <= NCSU_DOWN;
        NCSU_FULL: pstate <= NCSU_FULL;
        default: pstate <= NCSU_FULL;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_low <= 1'b0;
    end else begin
      power_low <= pstate == NCSU_DOWN || pstate == NCSU_AUTO_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_20 cause bits; receive-early hidden by receive-done
  always_comb begin
    cause = 8'h00;
    cause[C_FAIL] = adapter_fail;
    cause[C_TXDONE] = tx_status_pending || abort_cause;
    cause[C_FREE] = free_cause;
    cause[C_RXDONE] = rx_done;
    cause[C_RXEARLY] = rx_early && !rx_done;
    cause[C_REQ] = req_cause;
    cause[C_UPDATE] = stat_near_full;
    cause[C_LATCH] = int_out;
  end

  // RULE_21 both masks gate the interrupt
  assign int_cond = |(cause[7:1] & rz_mask[7:1] & int_mask[7:1]);

  // RULE_22 host reset clears latch; live conditions set it again
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_out <= 1'b0;
    end else if (int_cond && !host_reset) begin
      int_out <= 1'b1;
    end else if (host_reset || (is_cmd(cmd_ok, op, OP_ACK_INT) && arg[C_LATCH])) begin
      int_out <= 1'b0;
    end
  end

  // RULE_19 read-only status, either byte or both
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      io_rdata <= READ_NONE;
    end else if (io_rd && io_addr == STATUS_PORT) begin
      io_rdata[7:0] <= io_be[0] ? {cause[7:1] & rz_mask[7:1], int_out} : 8'h00;
      io_rdata[15:8] <= io_be[1] ? {window, cmd_busy, 4'h0} : 8'h00;
    end else begin
      io_rdata <= READ_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_free_thr_off;
    @(posedge clock) disable iff (rst)
    ack_free |=> avail_thr == AVAIL_DISABLED;
  endproperty
  a_free_thr_off: assert property (p_free_thr_off) else $error("threshold not disabled"); // RULE_03

  property p_free_set;
    @(posedge clock) disable iff (rst)
    free_rise |=> free_cause;
  endproperty
  a_free_set: assert property (p_free_set) else $error("free cause missed"); // RULE_02

  property p_start_whole;
    @(posedge clock) disable iff (rst)
    tx_pkt_pending && tx_pkt_whole |=> tx_start_ok;
  endproperty
  a_start_whole: assert property (p_start_whole) else $error("whole packet not started"); // RULE_04

  property p_stats_held;
    @(posedge clock) disable iff (rst)
    !stats_enabled && stat_event && stat_pend != 4'hF |=> !stat_apply && stat_pend == $past(stat_pend) + 4'h1;
  endproperty
  a_stats_held: assert property (p_stats_held) else $error("update not held"); // RULE_07

  property p_down_coax;
    @(posedge clock) disable iff (rst)
    pstate == NCSU_DOWN |-> !coax_on;
  endproperty
  a_down_coax: assert property (p_down_coax) else $error("converter on in power-down"); // RULE_15

  property p_down_stays;
    @(posedge clock) disable iff (rst)
    pstate == NCSU_DOWN && !is_cmd(cmd_ok, op, OP_POWER_UP) |=> pstate == NCSU_DOWN;
  endproperty
  a_down_stays: assert property (p_down_stays) else $error("woke without power-up"); // RULE_15

  property p_power_up;
    @(posedge clock) disable iff (rst)
    is_cmd(cmd_ok, op, OP_POWER_UP) |=> pstate == NCSU_FULL ##1 !power_low;
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up not taken"); // RULE_13

  property p_abort;
    @(posedge clock) disable iff (rst)
    reclaim_crossed && tx_collision |=> tx_abort && cause[C_TXDONE];
  endproperty
  a_abort: assert property (p_abort) else $error("collision abort missing"); // RULE_12

  property p_int_raise;
    @(posedge clock) disable iff (rst)
    int_cond && !host_reset |=> int_out;
  endproperty
  a_int_raise: assert property (p_int_raise) else $error("interrupt not raised"); // RULE_21

  property p_host_reset;
    @(posedge clock) disable iff (rst)
    host_reset |=> window == WIN_RESET && !req_cause;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("host reset incomplete"); // RULE_22
endmodule // ncsu_top

/* ncsu_medium_model.sv */
`timescale 1ns/1ps
module ncsu_medium_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Transmitter control
  input wire logic tx_start_ok,
  input wire logic tx_abort,
  // Wire progress
  output logic tx_byte_sent,
  output logic [ncsu_pkg::CNT_W-1:0] tx_sent_bytes
);
  import ncsu_pkg::*;
  // One byte onto the wire each cycle the transmitter may run
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_byte_sent <= 1'b0;
    end else begin
      tx_byte_sent <= tx_start_ok;
    end
  end
  // Count restarts only when the packet is thrown away
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_sent_bytes <= '0;
    end else if (tx_abort) begin
      tx_sent_bytes <= '0;
    end else if (tx_byte_sent && tx_sent_bytes != 11'h7FF) begin
      tx_sent_bytes <= tx_sent_bytes + 11'h001;
    end
  end
endmodule // ncsu_medium_model

/* test_nic_command_status_unit.sv */
`timescale 1ns/1ps
module test_nic_command_status_unit;
  import ncsu_pkg::*;
  logic clock = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, host_reset = 1'b0;
  logic [3:0] io_addr = 4'h0;
  logic [1:0] io_be = 2'h0;
  logic [15:0] io_wdata = 16'h0000, io_rdata, st;
  logic [CNT_W-1:0] tx_free_bytes = '0, tx_fifo_bytes = '0, tx_sent_bytes, thr;
  logic tx_pkt_pending = 1'b0, tx_pkt_whole = 1'b0, tx_byte_sent, tx_collision = 1'b0;
  logic tx_status_pop = 1'b0, tx_start_ok, tx_reclaim_byte, tx_abort;
  logic rx_activity = 1'b0, stat_event = 1'b0, stat_apply, stats_enabled;
  logic coax_on, power_low, int_out, seen_reclaim = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [1:0] rbe = 2'b11;
  logic [31:0] seed = 32'heabe6ffa;
  int failures = 0, compares = 0, napply = 0, cycles = 0;
  always #12.5 clock = ~clock;
  ncsu_top dut_u (.clock(clock), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_be(io_be), .io_wdata(io_wdata), .io_rdata(io_rdata), .host_reset(host_reset),
    .tx_free_bytes(tx_free_bytes), .tx_fifo_bytes(tx_fifo_bytes),
    .tx_pkt_pending(tx_pkt_pending), .tx_pkt_whole(tx_pkt_whole),
    .tx_sent_bytes(tx_sent_bytes), .tx_byte_sent(tx_byte_sent), .tx_collision(tx_collision),
    .tx_status_pending(lvl[4]), .tx_status_pop(tx_status_pop), .tx_start_ok(tx_start_ok),
    .tx_reclaim_byte(tx_reclaim_byte), .tx_abort(tx_abort), .rx_done(lvl[1]),
    .rx_early(lvl[2]), .rx_activity(rx_activity), .adapter_fail(lvl[0]),
    .stat_event(stat_event), .stat_near_full(lvl[3]), .stat_apply(stat_apply),
    .stats_enabled(stats_enabled), .coax_on(coax_on), .power_low(power_low),
    .int_out(int_out));
  ncsu_medium_model medium_u (.clock(clock), .rst(rst), .tx_start_ok(tx_start_ok),
    .tx_abort(tx_abort), .tx_byte_sent(tx_byte_sent), .tx_sent_bytes(tx_sent_bytes));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    napply <= napply + (stat_apply === 1'b1);
    if (tx_reclaim_byte === 1'b1) seen_reclaim <= 1'b1;
    cycles <= cycles + 1;
    // Generous ceiling, the full sequence needs about 33,000 cycles
    if (cycles == 40000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic cmd(input logic [4:0] op, input logic [10:0] arg);
    tick(1);
    io_wr = 1'b1;
    io_addr = CMD_PORT;
    io_be = 2'b11;
    io_wdata = {op, arg};
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(output logic [15:0] v);
    tick(1);
    io_rd = 1'b1;
    io_addr = STATUS_PORT;
    io_be = rbe;
    tick(1);
    io_rd = 1'b0;
    v = io_rdata;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Transmit may begin once fifo passes the dword-truncated threshold
  function automatic logic start_exp(input logic [10:0] f, input logic [10:0] t);
    return (t > THR_MAX) ? 1'b0 : (f > {t[10:2], 2'b00});
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    rst = 1'b0;
    rd(st);
    chk(st, 16'h0000);
    chk({coax_on, stats_enabled, power_low, int_out}, 16'h0000);
    cmd(OP_RZ_MASK, 11'h0FF);
    // Level causes at random, reserved bits read zero
    for (int i = 0; i < 6; i++) begin
      seed = nxt(seed);
      lvl = seed[4:0];
      tick(2);
      rd(st);
      // Receive-done hides receive-early
      chk(st & 16'h0FB6, {8'h00, lvl[3], 1'b0, lvl[2] & ~lvl[1], lvl[1], 1'b0, lvl[4], lvl[0], 1'b0});
    end
    lvl = 5'h00;
    // Free space cause, then disabled after ack and above 1792
    tx_free_bytes = 11'd50;
    cmd(OP_TX_AVAIL, 11'd100);
    tx_free_bytes = 11'd200;
    rd(st);
    chk(st[3], 1'b1);
    cmd(OP_ACK_INT, 11'h008);
    tx_free_bytes = 11'd50;
    tick(2);
    tx_free_bytes = 11'd200;
    rd(st);
    chk(st[3], 1'b0);
    cmd(OP_TX_AVAIL, 11'd1800);
    tx_free_bytes = 11'd2000;
    rd(st);
    chk(st[3], 1'b0);
    // Default start threshold of 1792 holds a 1792-byte fifo until the whole packet
    tx_pkt_pending = 1'b1;
    tx_fifo_bytes = 11'd1792;
    tick(3);
    chk(tx_start_ok, 1'b0);
    tx_pkt_whole = 1'b1;
    tick(3);
    chk(tx_start_ok, 1'b1);
    tx_pkt_whole = 1'b0;
    cmd(OP_TX_START, 11'd103);
    tx_fifo_bytes = 11'd101;
    tick(3);
    chk(tx_start_ok, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      thr = (i == 0) ? 11'd1800 : 11'(seed[10:0] % 1793);
      tx_fifo_bytes = seed[26:16];
      cmd(OP_TX_START, thr);
      tick(2);
      chk(tx_start_ok, start_exp(seed[26:16], thr));
    end
    // Reclaim off by default, then one step of 256 bytes
    cmd(OP_TX_START, 11'd0);
    tx_fifo_bytes = 11'd2000;
    seen_reclaim = 1'b0;
    tick(320);
    chk(seen_reclaim, 1'b0);
    cmd(OP_RECLAIM, 11'd1);
    tick(4);
    chk(seen_reclaim, 1'b1);
    tx_collision = 1'b1;
    tick(1);
    tx_collision = 1'b0;
    chk(tx_abort, 1'b1);
    tx_pkt_pending = 1'b0;
    rd(st);
    chk(st[2], 1'b1);
    tx_status_pop = 1'b1;
    tick(1);
    tx_status_pop = 1'b0;
    // Updates held while disabled, replayed after enable
    for (int i = 0; i < 3; i++) begin
      stat_event = 1'b1;
      tick(1);
      stat_event = 1'b0;
      tick(1);
    end
    chk(16'(napply), 16'd0);
    cmd(OP_STATS_ON, 11'd0);
    tick(8);
    chk(16'(napply), 16'd3);
    chk(stats_enabled, 1'b1);
    // Host pauses collection around a counter read
    cmd(OP_STATS_OFF, 11'd0);
    chk(stats_enabled, 1'b0);
    cmd(OP_STATS_ON, 11'd0);
    // Interrupt through both masks
    cmd(OP_ACK_INT, 11'h0FF);
    cmd(OP_INT_MASK, 11'h0FF);
    cmd(OP_REQ_INT, 11'd0);
    tick(2);
    chk(int_out, 1'b1);
    cmd(OP_RZ_MASK, 11'h000);
    cmd(OP_ACK_INT, 11'h041);
    cmd(OP_REQ_INT, 11'd0);
    tick(2);
    chk(int_out, 1'b0);
    cmd(OP_RZ_MASK, 11'h0FF);
    cmd(OP_INT_MASK, 11'h000);
    // Converter, window and power states
    cmd(OP_COAX_ON, 11'd0);
    chk(coax_on, 1'b1);
    cmd(OP_COAX_OFF, 11'd0);
    chk(coax_on, 1'b0);
    // Host keeps off the AUI for 800 us after the stop
    tick(32000);
    cmd(OP_COAX_ON, 11'd0);
    cmd(OP_SEL_WINDOW, 11'd3);
    // Either byte alone; the other reads zero
    rbe = 2'b01;
    rd(st);
    chk(st, 16'h0041);
    rbe = 2'b10;
    rd(st);
    chk(st, 16'h6000);
    rbe = 2'b11;
    cmd(OP_POWER_DOWN, 11'd0);
    chk({coax_on, power_low}, 16'h0001);
    cmd(OP_STATS_OFF, 11'd0);
    rx_activity = 1'b1;
    tick(3);
    chk({stats_enabled, power_low}, 16'h0003);
    rx_activity = 1'b0;
    cmd(OP_POWER_UP, 11'd0);
    // Transmit side emptied as a transmit reset would
    tx_fifo_bytes = '0;
    rd(st);
    chk({power_low, st[15:12]}, 16'h0007);
    tick(WAKE_CYCLES + 2);
    rd(st);
    chk({coax_on, st[12]}, 16'h0000);
    cmd(OP_POWER_UP, 11'd0);
    rd(st);
    chk(st[12], 1'b0);
    host_reset = 1'b1;
    tick(1);
    host_reset = 1'b0;
    rd(st);
    chk(st, 16'h0000);
    cmd(OP_POWER_AUTO, 11'd0);
    tick(3);
    chk(power_low, 1'b1);
    rx_activity = 1'b1;
    tick(3);
    chk(power_low, 1'b0);
    rx_activity = 1'b0;
    // Host returns to full power before anything else
    cmd(OP_POWER_UP, 11'd0);
    tick(3);
    chk(power_low, 1'b0);
    end_of_test();
  end
endmodule // test_nic_command_status_unit
